// File: include/e1_ctrl_pkg.sv
// constants shared by the e1 transmit and common control block
package e1_ctrl_pkg;
    // register offsets on the parallel port
    localparam logic [7:0] TX_CTRL_ONE_OFFSET = 8'h12;
    localparam logic [7:0] TX_CTRL_TWO_OFFSET = 8'h13;
    localparam logic [7:0] COMMON_CTRL_OFFSET = 8'h14;
    // reset values
    localparam logic [7:0] TX_CTRL_ONE_RESET  = 8'h00;
    localparam logic [7:0] TX_CTRL_TWO_RESET  = 8'h00;
    localparam logic [7:0] COMMON_CTRL_RESET  = 8'h00;
    // transmit control one fields
    localparam int OUTPUT_FORMAT_BIT     = 7;
    localparam int TX_PASSTHROUGH_BIT    = 6;
    localparam int TX_SLOT16_SOURCE_BIT  = 5;
    localparam int TX_UNFRAMED_ONES_BIT  = 4;
    localparam int TX_INTL_SOURCE_BIT    = 3;
    localparam int TX_SIG_ALL_ONES_BIT   = 2;
    localparam int TX_SYNC_MODE_BIT      = 1;
    localparam int TX_SYNC_DIR_BIT       = 0;
    // transmit control two fields
    localparam int EXTRA_SELECT_LSB      = 3;
    localparam int AUTO_FAR_END_BIT      = 1;
    localparam int PIN_FUNCTION_BIT      = 0;
    // common control fields
    localparam int LOCAL_LOOP_BIT        = 7;
    localparam int TX_LINE_CODE_BIT      = 6;
    localparam int TX_BLOCK_MARK_BIT     = 5;
    localparam int TX_CHECK_BIT          = 4;
    localparam int RX_SIG_MODE_BIT       = 3;
    localparam int RX_LINE_CODE_BIT      = 2;
    localparam int RX_BLOCK_MARK_BIT     = 1;
    localparam int RX_CHECK_BIT          = 0;
    // frame geometry
    localparam logic [4:0] ALIGN_SLOT    = 5'h00;
    localparam logic [4:0] SIGNAL_SLOT   = 5'h10;
    localparam logic [4:0] MARK_SLOT     = 5'h1A;
    localparam logic [2:0] FIRST_BIT     = 3'h0;
    localparam logic [3:0] LAST_FRAME    = 4'hF;
endpackage : e1_ctrl_pkg

// File: hdl/e1_frame_counter.sv
// bit, slot and frame position counter advanced by a clock edge enable
module e1_frame_counter (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       step,
    input  wire logic       sync_in,
    output logic [2:0]      bit_pos,
    output logic [4:0]      slot_pos,
    output logic [3:0]      frame_pos
);
    logic [11:0] count_reg;
    logic [11:0] count_next;

    // sync restarts the position so the next step is bit 0 of slot 0
    assign count_next = sync_in ? 12'h000 : count_reg + 12'h001;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 12'h000;
        end else if (step) begin
            count_reg <= count_next;
        end
    end

    assign bit_pos   = count_reg[2:0];
    assign slot_pos  = count_reg[7:3];
    assign frame_pos = count_reg[11:8];
endmodule : e1_frame_counter

// File: hdl/e1_tx_common_ctrl.sv
// transmit and common control of an e1 framer with local loopback
module e1_tx_common_ctrl (
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] DATA_IN,
    output logic [7:0]      DATA_OUT,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic [4:0] RX_EXTRA_SELECT,
    input  wire logic       TRANSMIT_CLOCK,
    input  wire logic       RECEIVE_CLOCK,
    input  wire logic       TRANSMIT_SERIAL_INPUT,
    input  wire logic       TRANSMIT_DATALINK_PIN,
    input  wire logic [7:0] TX_ALIGN_FRAME_REGISTER,
    input  wire logic [7:0] TX_NONALIGN_FRAME_REGISTER,
    input  wire logic       TRANSMIT_SYNC_PIN_IN,
    output logic            TRANSMIT_SYNC_PIN_OUT,
    output logic            TRANSMIT_SYNC_PIN_OE_N,
    output logic            TRANSMIT_POSITIVE_RAIL,
    output logic            TRANSMIT_NEGATIVE_RAIL,
    output logic            TRANSMIT_CHANNEL_BLOCK,
    input  wire logic       RECEIVE_POSITIVE_RAIL,
    input  wire logic       RECEIVE_NEGATIVE_RAIL,
    output logic            RECEIVE_CHANNEL_BLOCK,
    output logic            RECEIVE_DATALINK_PIN,
    output logic            RX_DATA,
    output logic            RX_SIGNALING_MODE,
    output logic            TX_LINE_CODE_ENABLE,
    output logic            RX_LINE_CODE_ENABLE,
    output logic            TX_CHECK_ENABLE,
    output logic            RX_CHECK_ENABLE
);
    // control registers
    logic [7:0] tx_ctrl_one_reg;
    logic [7:0] tx_ctrl_two_reg;
    logic [7:0] common_ctrl_reg;

    // pin synchronisers, two stages each
    logic [1:0] transmit_clock_sync_reg;
    logic [1:0] rclk_sync_reg;
    logic [1:0] transmit_serial_input_sync_reg;
    logic [1:0] transmit_datalink_pin_sync_reg;
    logic [1:0] transmit_sync_pin_sync_reg;
    logic [1:0] receive_positive_rail_sync_reg;
    logic [1:0] receive_negative_rail_sync_reg;
    logic       transmit_clock_last_reg;
    logic       rclk_last_reg;
    logic       transmit_sync_pin_last_reg;
    logic       transmit_sync_pin_pending_reg;

    // output and receive path flops
    logic       transmit_positive_rail_reg;
    logic       transmit_negative_rail_reg;
    logic       transmit_sync_pin_out_reg;
    logic       transmit_channel_block_reg;
    logic       receive_channel_block_reg;
    logic       receive_datalink_pin_reg;
    logic       rx_data_reg;

    // register decode and field picks
    wire        sel_one           = ADDR == e1_ctrl_pkg::TX_CTRL_ONE_OFFSET;
    wire        sel_two           = ADDR == e1_ctrl_pkg::TX_CTRL_TWO_OFFSET;
    wire        sel_common        = ADDR == e1_ctrl_pkg::COMMON_CTRL_OFFSET;
    wire        output_format_select = tx_ctrl_one_reg[e1_ctrl_pkg::OUTPUT_FORMAT_BIT];
    wire        tx_slot0_passthrough = tx_ctrl_one_reg[e1_ctrl_pkg::TX_PASSTHROUGH_BIT];
    wire        tx_signaling_all_ones = tx_ctrl_one_reg[e1_ctrl_pkg::TX_SIG_ALL_ONES_BIT];
    wire        tx_sync_mode      = tx_ctrl_one_reg[e1_ctrl_pkg::TX_SYNC_MODE_BIT];
    wire        tx_sync_direction = tx_ctrl_one_reg[e1_ctrl_pkg::TX_SYNC_DIR_BIT];
    wire [4:0]  extra_select      = tx_ctrl_two_reg[e1_ctrl_pkg::EXTRA_SELECT_LSB +: 5];
    wire        local_loop_enable = common_ctrl_reg[e1_ctrl_pkg::LOCAL_LOOP_BIT];
    wire        tx_block_mark_enable = common_ctrl_reg[e1_ctrl_pkg::TX_BLOCK_MARK_BIT];
    wire        rx_block_mark_enable = common_ctrl_reg[e1_ctrl_pkg::RX_BLOCK_MARK_BIT];

    // read mux, unmapped addresses read zero
    assign DATA_OUT = !RD       ? 8'h00 :
                      sel_one   ? tx_ctrl_one_reg :
                      sel_two   ? tx_ctrl_two_reg :
                      sel_common ? common_ctrl_reg : 8'h00;

    // register writes; unassigned bits stored as written
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            tx_ctrl_one_reg <= e1_ctrl_pkg::TX_CTRL_ONE_RESET;
            tx_ctrl_two_reg <= e1_ctrl_pkg::TX_CTRL_TWO_RESET;
            common_ctrl_reg <= e1_ctrl_pkg::COMMON_CTRL_RESET;
        end else if (WR) begin
            if (sel_one) tx_ctrl_one_reg <= DATA_IN;
            if (sel_two) tx_ctrl_two_reg <= DATA_IN;
            if (sel_common) common_ctrl_reg <= DATA_IN;
        end
    end

    // synchronisers: first stage read only by second
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            transmit_clock_sync_reg  <= 2'h0;
            rclk_sync_reg  <= 2'h0;
            transmit_serial_input_sync_reg  <= 2'h0;
            transmit_datalink_pin_sync_reg <= 2'h0;
            transmit_sync_pin_sync_reg <= 2'h0;
            receive_positive_rail_sync_reg  <= 2'h0;
            receive_negative_rail_sync_reg  <= 2'h0;
        end else begin
            transmit_clock_sync_reg  <= {transmit_clock_sync_reg[0], TRANSMIT_CLOCK};
            rclk_sync_reg  <= {rclk_sync_reg[0], RECEIVE_CLOCK};
            transmit_serial_input_sync_reg  <= {transmit_serial_input_sync_reg[0], TRANSMIT_SERIAL_INPUT};
            transmit_datalink_pin_sync_reg <= {transmit_datalink_pin_sync_reg[0], TRANSMIT_DATALINK_PIN};
            transmit_sync_pin_sync_reg <= {transmit_sync_pin_sync_reg[0], TRANSMIT_SYNC_PIN_IN};
            receive_positive_rail_sync_reg  <= {receive_positive_rail_sync_reg[0], RECEIVE_POSITIVE_RAIL};
            receive_negative_rail_sync_reg  <= {receive_negative_rail_sync_reg[0], RECEIVE_NEGATIVE_RAIL};
        end
    end

    // edge finders on the synchronised clocks and sync pin
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            transmit_clock_last_reg  <= 1'b0;
            rclk_last_reg  <= 1'b0;
            transmit_sync_pin_last_reg <= 1'b0;
        end else begin
            transmit_clock_last_reg  <= transmit_clock_sync_reg[1];
            rclk_last_reg  <= rclk_sync_reg[1];
            transmit_sync_pin_last_reg <= transmit_sync_pin_sync_reg[1];
        end
    end

    wire tx_step    = transmit_clock_sync_reg[1] & ~transmit_clock_last_reg;
    wire rclk_step  = rclk_sync_reg[1] & ~rclk_last_reg;
    // loopback replaces the receive clock with the transmit clock
    wire rx_step    = local_loop_enable ? tx_step : rclk_step;
    wire transmit_sync_pin_rise = transmit_sync_pin_sync_reg[1] & ~transmit_sync_pin_last_reg;
    wire transmit_sync_pin_seen = transmit_sync_pin_pending_reg | transmit_sync_pin_rise;
    // an edge seldom lands on a step cycle, so it waits for the next step
    wire transmit_sync_pin_pending_next = ~tx_sync_direction & ~tx_step & transmit_sync_pin_seen;
    // sync pin only realigns the counter when it is an input
    wire tx_realign = ~tx_sync_direction & transmit_sync_pin_seen & tx_step;

    // pending sync edge, dropped by the step that uses it or by output mode
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            transmit_sync_pin_pending_reg <= 1'b0;
        end else begin
            transmit_sync_pin_pending_reg <= transmit_sync_pin_pending_next;
        end
    end

    wire [2:0] tx_bit;
    wire [4:0] tx_slot;
    wire [3:0] tx_frame;
    wire [2:0] rx_bit;
    wire [4:0] rx_slot;
    wire [3:0] rx_frame;

    e1_frame_counter tx_position (
        .clk       (CLK),
        .nrst      (NRST),
        .step      (tx_step),
        .sync_in   (tx_realign),
        .bit_pos   (tx_bit),
        .slot_pos  (tx_slot),
        .frame_pos (tx_frame)
    );

    e1_frame_counter rx_position (
        .clk       (CLK),
        .nrst      (NRST),
        .step      (rx_step),
        .sync_in   (1'b0),
        .bit_pos   (rx_bit),
        .slot_pos  (rx_slot),
        .frame_pos (rx_frame)
    );

    // transmit bit selection; frame parity picks align or non-align word
    wire       align_frame  = ~tx_frame[0];
    wire [7:0] overhead_word = align_frame ? TX_ALIGN_FRAME_REGISTER
                                           : TX_NONALIGN_FRAME_REGISTER;
    wire       internal_bit = overhead_word[3'h7 - tx_bit];
    wire       in_slot0     = tx_slot == e1_ctrl_pkg::ALIGN_SLOT;
    wire       in_slot16    = tx_slot == e1_ctrl_pkg::SIGNAL_SLOT;
    // extra bits 4..8 are bit positions 3..7 of non-align slot 0
    wire       extra_pos    = in_slot0 & ~align_frame & (tx_bit >= 3'h3);
    wire [2:0] extra_idx    = tx_bit - 3'h3;
    wire       use_link     = extra_pos & extra_select[extra_idx];
    wire       slot0_bit    = use_link ? transmit_datalink_pin_sync_reg[1] :
                              tx_slot0_passthrough ? transmit_serial_input_sync_reg[1]
                                                   : internal_bit;
    wire       tx_bit_value = in_slot0 ? slot0_bit :
                              (in_slot16 & tx_signaling_all_ones) ? 1'b1
                                                                  : transmit_serial_input_sync_reg[1];
    // alternate mark polarity is kept simple: ones toggle between rails
    logic ami_phase_reg;
    wire  next_pos = output_format_select ? tx_bit_value
                                          : tx_bit_value & ~ami_phase_reg;
    wire  next_neg = output_format_select ? 1'b0 : tx_bit_value & ami_phase_reg;

    // sync pulse, every frame start or, in multiframe mode, the start of the last frame
    wire  frame_start = in_slot0 & (tx_bit == e1_ctrl_pkg::FIRST_BIT);
    wire  sync_pulse  = frame_start &
                        (~tx_sync_mode | (tx_frame == e1_ctrl_pkg::LAST_FRAME));

    // transmit output flops, updated per transmit bit
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            transmit_positive_rail_reg      <= 1'b0;
            transmit_negative_rail_reg      <= 1'b0;
            ami_phase_reg <= 1'b0;
            transmit_sync_pin_out_reg <= 1'b0;
            transmit_channel_block_reg    <= 1'b0;
        end else if (tx_step) begin
            transmit_positive_rail_reg      <= next_pos;
            transmit_negative_rail_reg      <= next_neg;
            ami_phase_reg <= ami_phase_reg ^ tx_bit_value;
            transmit_sync_pin_out_reg <= sync_pulse;
            transmit_channel_block_reg    <= tx_block_mark_enable & (tx_slot == e1_ctrl_pkg::MARK_SLOT)
                             & (tx_bit == e1_ctrl_pkg::FIRST_BIT);
        end
    end

    // receive source: own rails in loopback, line rails otherwise
    wire rx_pos = local_loop_enable ? transmit_positive_rail_reg : receive_positive_rail_sync_reg[1];
    wire rx_neg = local_loop_enable ? transmit_negative_rail_reg : receive_negative_rail_sync_reg[1];
    wire rx_bit_value = rx_pos | rx_neg;
    wire rx_extra_pos = (rx_slot == e1_ctrl_pkg::ALIGN_SLOT) & rx_frame[0] & (rx_bit >= 3'h3);
    wire [2:0] rx_extra_idx = rx_bit - 3'h3;

    // receive side flops; loopback changes only sources, not functions
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rx_data_reg <= 1'b0;
            receive_channel_block_reg  <= 1'b0;
            receive_datalink_pin_reg   <= 1'b0;
        end else if (rx_step) begin
            rx_data_reg <= rx_bit_value;
            receive_channel_block_reg  <= rx_block_mark_enable & (rx_slot == e1_ctrl_pkg::MARK_SLOT)
                           & (rx_bit == e1_ctrl_pkg::FIRST_BIT);
            if (rx_extra_pos & RX_EXTRA_SELECT[rx_extra_idx]) begin
                receive_datalink_pin_reg <= rx_bit_value;
            end
        end
    end

    assign TRANSMIT_POSITIVE_RAIL = transmit_positive_rail_reg;
    assign TRANSMIT_NEGATIVE_RAIL = transmit_negative_rail_reg;
    assign TRANSMIT_SYNC_PIN_OUT  = transmit_sync_pin_out_reg;
    assign TRANSMIT_SYNC_PIN_OE_N = ~tx_sync_direction;
    assign TRANSMIT_CHANNEL_BLOCK = transmit_channel_block_reg;
    assign RECEIVE_CHANNEL_BLOCK  = receive_channel_block_reg;
    assign RECEIVE_DATALINK_PIN   = receive_datalink_pin_reg;
    assign RX_DATA                = rx_data_reg;
    // mode levels handed to the rest of the framer
    assign RX_SIGNALING_MODE   = common_ctrl_reg[e1_ctrl_pkg::RX_SIG_MODE_BIT];
    assign TX_LINE_CODE_ENABLE = common_ctrl_reg[e1_ctrl_pkg::TX_LINE_CODE_BIT];
    assign RX_LINE_CODE_ENABLE = common_ctrl_reg[e1_ctrl_pkg::RX_LINE_CODE_BIT];
    assign TX_CHECK_ENABLE     = common_ctrl_reg[e1_ctrl_pkg::TX_CHECK_BIT];
    assign RX_CHECK_ENABLE     = common_ctrl_reg[e1_ctrl_pkg::RX_CHECK_BIT];
endmodule : e1_tx_common_ctrl

// File: dv/e1_ctrl_checker_sva.sv
// concurrent checks on the ports of the e1 transmit and common control block
module e1_ctrl_checker (
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] DATA_IN,
    input  wire logic [7:0] DATA_OUT,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic       TRANSMIT_SYNC_PIN_OE_N,
    input  wire logic       TRANSMIT_CHANNEL_BLOCK,
    input  wire logic       RECEIVE_CHANNEL_BLOCK,
    input  wire logic       RX_SIGNALING_MODE,
    input  wire logic       TX_LINE_CODE_ENABLE,
    input  wire logic       RX_LINE_CODE_ENABLE,
    input  wire logic       TX_CHECK_ENABLE,
    input  wire logic       RX_CHECK_ENABLE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] t1_reg;
    logic [7:0] t1_d_reg;
    logic [7:0] cc_reg;
    logic [7:0] cc_d_reg;
    logic       mapped;
    logic       calm;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // levels are only judged once a write has had a cycle to land
    assign mapped = ADDR inside {8'h12, 8'h13, 8'h14};
    assign calm   = (t1_reg == t1_d_reg) && (cc_reg == cc_d_reg);
    // shadow copies of the two control bytes that drive levels
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            t1_reg   <= 8'h00;
            t1_d_reg <= 8'h00;
            cc_reg   <= 8'h00;
            cc_d_reg <= 8'h00;
        end else begin
            t1_reg   <= (WR && ADDR == e1_ctrl_pkg::TX_CTRL_ONE_OFFSET) ? DATA_IN : t1_reg;
            cc_reg   <= (WR && ADDR == e1_ctrl_pkg::COMMON_CTRL_OFFSET) ? DATA_IN : cc_reg;
            t1_d_reg <= t1_reg;
            cc_d_reg <= cc_reg;
        end
    end
    wr_readback_a: assert property (
        WR && mapped ##1 RD && !WR && $stable(ADDR) |-> DATA_OUT == $past(DATA_IN))
        else $error("control byte read back wrong");
    unmapped_zero_a: assert property (RD && !mapped |-> DATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    idle_zero_a: assert property (!RD |-> DATA_OUT == 8'h00)
        else $error("read data without read enable");
    sync_dir_a: assert property (calm |-> TRANSMIT_SYNC_PIN_OE_N == !t1_reg[0])
        else $error("sync pin direction wrong");
    sig_mode_a: assert property (calm |-> RX_SIGNALING_MODE == cc_reg[3])
        else $error("signaling mode level wrong");
    code_enables_a: assert property (calm |->
        {TX_LINE_CODE_ENABLE, RX_LINE_CODE_ENABLE, TX_CHECK_ENABLE, RX_CHECK_ENABLE}
        == {cc_reg[6], cc_reg[2], cc_reg[4], cc_reg[0]}) else $error("enable levels wrong");
    tx_mark_a: assert property (
        $rose(TRANSMIT_CHANNEL_BLOCK) |-> cc_reg[5] || cc_d_reg[5])
        else $error("transmit block mark while disabled");
    rx_mark_a: assert property (
        $rose(RECEIVE_CHANNEL_BLOCK) |-> cc_reg[1] || cc_d_reg[1])
        else $error("receive block mark while disabled");
    mark_width_a: assert property (
        $rose(TRANSMIT_CHANNEL_BLOCK) |=> TRANSMIT_CHANNEL_BLOCK [*8] ##[1:8]
        !TRANSMIT_CHANNEL_BLOCK) else $error("block mark not one bit long");
    cover property (RD && ADDR == 8'h14 && DATA_OUT[7]);
    cover property ($rose(TRANSMIT_CHANNEL_BLOCK));
    cover property ($rose(RECEIVE_CHANNEL_BLOCK));
endmodule : e1_ctrl_checker

// File: dv/e1_line_partner.sv
// behavioural line interface and serial backplane facing the control block
module e1_line_partner (
    output logic            transmit_clock,
    output logic            rclk,
    output logic            receive_positive_rail,
    output logic            receive_negative_rail,
    output logic            transmit_serial_input,
    output logic            transmit_datalink_pin,
    output logic            sync_drive,
    input  wire logic       rclk_run,
    input  wire logic       rail_level,
    input  wire logic       transmit_serial_input_level,
    input  wire logic       transmit_datalink_pin_level,
    input  wire logic       sync_level,
    input  wire logic       sync_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // transmit clock free running at 64 ns
    initial begin
        transmit_clock = 1'b0;
        forever #32 transmit_clock = ~transmit_clock;
    end
    // receive clock at an unrelated phase, can be held still
    initial begin
        rclk = 1'b0;
        #7;
        forever #32 rclk = rclk_run ? ~rclk : rclk;
    end
    // backplane data moves on the edge the block does not sample
    logic sync_q;
    initial {transmit_serial_input, transmit_datalink_pin, sync_q} = 3'h0;
    always @(negedge transmit_clock) begin
        transmit_serial_input   <= transmit_serial_input_level;
        transmit_datalink_pin  <= transmit_datalink_pin_level;
        sync_q <= sync_level;
    end
    // positive line rail follows the request directly, even with the clock stopped; negative rail held low
    assign receive_positive_rail = rail_level;
    assign receive_negative_rail = 1'b0;
    // drives the requested sync level only while the block leaves the pin an input
    assign sync_drive = sync_oe_n ? sync_q : 1'b1;
endmodule : e1_line_partner

// File: dv/testbench.sv
// self-checking bench for the e1 transmit and common control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
    logic       clk, nrst, wr, rd, rclk_run, rail_lvl, transmit_serial_input_lvl, transmit_datalink_pin_lvl, transmit_clock, rclk;
    logic       transmit_serial_input, transmit_datalink_pin, receive_positive_rail, receive_negative_rail, p_sync, s_pin, s_out, s_oe_n, transmit_positive_rail, transmit_negative_rail, tcb, rcb, rxd;
    logic [7:0] addr, din, dout;
    logic [4:0] lv, rx_sel;
    logic       receive_datalink_pin, sync_lvl;
    int         err_count, cmp_count, n;
    row_t       rows [5] = '{'{8'h12, 8'hA5, 8'hA5}, '{8'h13, 8'hF8, 8'hF8},
        '{8'h14, 8'h5D, 8'h5D}, '{8'h15, 8'hFF, 8'h00}, '{8'h11, 8'hFF, 8'h00}};
    // sync pin wire: whoever has the enable drives it
    assign s_pin = s_oe_n ? p_sync : s_out;
    e1_tx_common_ctrl dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr), .DATA_IN(din),
        .DATA_OUT(dout), .WR(wr), .RD(rd), .RX_EXTRA_SELECT(rx_sel), .TRANSMIT_CLOCK(transmit_clock),
        .RECEIVE_CLOCK(rclk), .TRANSMIT_SERIAL_INPUT(transmit_serial_input), .TRANSMIT_DATALINK_PIN(transmit_datalink_pin),
        .TX_ALIGN_FRAME_REGISTER(8'h00), .TX_NONALIGN_FRAME_REGISTER(8'h00),
        .TRANSMIT_SYNC_PIN_IN(s_pin), .TRANSMIT_SYNC_PIN_OUT(s_out),
        .TRANSMIT_SYNC_PIN_OE_N(s_oe_n), .TRANSMIT_POSITIVE_RAIL(transmit_positive_rail),
        .TRANSMIT_NEGATIVE_RAIL(transmit_negative_rail), .TRANSMIT_CHANNEL_BLOCK(tcb),
        .RECEIVE_POSITIVE_RAIL(receive_positive_rail), .RECEIVE_NEGATIVE_RAIL(receive_negative_rail),
        .RECEIVE_CHANNEL_BLOCK(rcb), .RECEIVE_DATALINK_PIN(receive_datalink_pin), .RX_DATA(rxd),
        .RX_SIGNALING_MODE(lv[4]), .TX_LINE_CODE_ENABLE(lv[3]), .RX_LINE_CODE_ENABLE(lv[2]),
        .TX_CHECK_ENABLE(lv[1]), .RX_CHECK_ENABLE(lv[0]));
    e1_line_partner line_u (.transmit_clock(transmit_clock), .rclk(rclk), .receive_positive_rail(receive_positive_rail), .receive_negative_rail(receive_negative_rail), .transmit_serial_input(transmit_serial_input),
        .transmit_datalink_pin(transmit_datalink_pin), .sync_drive(p_sync), .rclk_run(rclk_run), .rail_level(rail_lvl),
        .transmit_serial_input_level(transmit_serial_input_lvl), .transmit_datalink_pin_level(transmit_datalink_pin_lvl), .sync_level(sync_lvl),
        .sync_oe_n(s_oe_n));
    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // write strobe is left high so a following write keeps it up
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        din = d;
        wr = 1'b1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        wr = 1'b0;
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        check({8'h00, dout}, {8'h00, exp});
        rd = 1'b0;
    endtask : rd_reg
    // counts high samples mid-bit; eight bits first to flush the pipeline
    task automatic count(input int sel, input int bits);
        logic [5:0] v;
        n = 0;
        for (int i = -8; i < bits; i++) begin
            // with the receive clock held, the receive side follows the transmit clock
            if (sel == 4 && rclk_run) @(negedge rclk);
            else @(negedge transmit_clock);
            v = {transmit_negative_rail, rcb, tcb, s_out, rxd, transmit_positive_rail | transmit_negative_rail};
            if (i >= 0 && v[sel] === 1'b1) n++;
        end
    endtask : count
    task automatic report_and_stop;
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // watchdog a little past the expected run length of about 430 us
    initial begin
        #480000;
        err_count++;
        report_and_stop();
    end
    initial begin
        {nrst, wr, rd, rail_lvl, transmit_serial_input_lvl, transmit_datalink_pin_lvl} = 6'h00;
        {addr, din} = 16'h0000;
        rclk_run = 1'b1;
        rx_sel = 5'h00;
        sync_lvl = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 3; i++) rd_reg(8'(8'h12 + i), 8'h00);
        check(16'(s_oe_n), 16'h0001);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, rows[i].q);
        end
        check(16'(lv), 16'h001F);
        check(16'(s_oe_n), 16'h0000);
        wr_reg(8'h12, 8'h08);
        wr_reg(8'h13, 8'h00);
        wr_reg(8'h14, 8'h22);
        count(3, 256);
        check(16'(n), 16'h0001);
        check(16'(lv), 16'h0000);
        count(4, 256);
        check(16'(n), 16'h0001);
        wr_reg(8'h14, 8'h00);
        count(3, 256);
        check(16'(n), 16'h0000);
        // slot 0 words are zero, serial input all ones
        transmit_serial_input_lvl = 1'b1;
        count(0, 512);
        check(16'(n), 16'd496);
        wr_reg(8'h12, 8'h40);
        count(0, 512);
        check(16'(n), 16'd512);
        wr_reg(8'h12, 8'h08);
        wr_reg(8'h13, 8'hF8);
        transmit_datalink_pin_lvl = 1'b1;
        count(0, 512);
        check(16'(n), 16'd501);
        wr_reg(8'h13, 8'h88);
        count(0, 512);
        check(16'(n), 16'd498);
        wr_reg(8'h13, 8'h00);
        transmit_serial_input_lvl = 1'b0;
        wr_reg(8'h12, 8'h0C);
        count(0, 256);
        check(16'(n), 16'd8);
        wr_reg(8'h12, 8'h08);
        count(0, 256);
        check(16'(n), 16'd0);
        wr_reg(8'h12, 8'h01);
        count(2, 512);
        check(16'(n), 16'd2);
        check(16'(s_oe_n), 16'h0000);
        wr_reg(8'h12, 8'h03);
        count(2, 512);
        check(16'(n <= 1), 16'h0001);
        // loopback with the receive clock stopped
        wr_reg(8'h12, 8'h40);
        transmit_serial_input_lvl = 1'b1;
        rclk_run = 1'b0;
        wr_reg(8'h14, 8'h80);
        count(1, 64);
        check(16'(n), 16'd64);
        count(5, 64);
        check(16'(n), 16'h0020);
        wr_reg(8'h12, 8'hC0);
        count(5, 64);
        check(16'(n), 16'h0000);
        count(0, 64);
        check(16'(n), 16'h0040);
        transmit_serial_input_lvl = 1'b0;
        rail_lvl = 1'b1;
        count(1, 64);
        check(16'(n), 16'd0);
        wr_reg(8'h14, 8'hA2);
        count(3, 256);
        check(16'(n), 16'h0001);
        count(4, 256);
        check(16'(n), 16'h0001);
        wr_reg(8'h14, 8'h00);
        rclk_run = 1'b1;
        count(1, 64);
        check(16'(n), 16'd64);
        check(16'(s_oe_n), 16'h0001);
        // received extra bit 4 reaches the datalink pin only when selected
        check(16'(receive_datalink_pin), 16'h0000);
        @(negedge clk);
        rx_sel = 5'h01;
        count(0, 512);
        check(16'(receive_datalink_pin), 16'h0001);
        rail_lvl = 1'b0;
        count(0, 512);
        check(16'(receive_datalink_pin), 16'h0000);
        // a sync edge at the input restarts the frame, so the mark comes 210 bits on
        wr_reg(8'h12, 8'h00);
        wr_reg(8'h14, 8'h20);
        @(negedge transmit_clock);
        sync_lvl = 1'b1;
        count(3, 192);
        check(16'(n), 16'h0000);
        count(3, 16);
        check(16'(n), 16'h0001);
        sync_lvl = 1'b0;
        wr_reg(8'h12, 8'h01);
        wr_reg(8'h14, 8'h48);
        rd_reg(8'h14, 8'h48);
        check(16'(lv), 16'h0018);
        wr_reg(8'h14, 8'h15);
        rd_reg(8'h14, 8'h15);
        check(16'(lv), 16'h0007);
        check(16'(s_oe_n), 16'h0000);
        // reset in mid-run clears the control bytes
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        check(16'(lv), 16'h0000);
        check(16'(s_oe_n), 16'h0001);
        rd_reg(8'h12, 8'h00);
        rd_reg(8'h14, 8'h00);
        report_and_stop();
    end
endmodule : testbench
bind e1_tx_common_ctrl e1_ctrl_checker chk_u (.CLK, .NRST, .ADDR, .DATA_IN, .DATA_OUT, .WR,
    .RD, .TRANSMIT_SYNC_PIN_OE_N, .TRANSMIT_CHANNEL_BLOCK, .RECEIVE_CHANNEL_BLOCK,
    .RX_SIGNALING_MODE, .TX_LINE_CODE_ENABLE, .RX_LINE_CODE_ENABLE, .TX_CHECK_ENABLE,
    .RX_CHECK_ENABLE);
